// >>> common/aalc_consts.svh
`ifndef AALC_CONSTS_SVH
`define AALC_CONSTS_SVH
`define AALC_OFS_CTRL 4'h0
`define AALC_OFS_CFG 4'h4
`define AALC_OFS_GAIN 4'h8
`define AALC_OFS_STAT 4'hC
`define AALC_CTRL_HPA 0
`define AALC_CTRL_HPP 1
`define AALC_CTRL_SPEAKER_POWER 2
`define AALC_CTRL_SPSN 3
`define AALC_CTRL_MONO 4
`define AALC_CTRL_ALCEN 5
`define AALC_CTRL_ZCD 6
`define AALC_CFG_LMAT 0
`define AALC_CFG_LTM 2
`define AALC_CFG_ZTM 4
`define AALC_CFG_WTM 6
`define AALC_CFG_REF 8
`define AALC_CTRL_RST 7'h00
`define AALC_CFG_RST 15'h3000
`define AALC_GAIN_RST 7'h10
`define AALC_SPK_LIM_FS 14'h0002
`define AALC_SPK_REC_FS 14'h0800
`define AALC_SPK_ZTO_FS 14'h0800
`define AALC_SPK_INIT_FS 14'h0800
`define AALC_TMO_BASE_FS 14'h0080
`endif

// >>> common/aalc_pkg.sv
package aalc_pkg;
  typedef logic [13:0] aalc_cnt_t;
  typedef enum logic [1:0] {
    ALC_IDLE = 2'b00,
    ALC_LIMIT = 2'b01,
    ALC_WAIT = 2'b10
  } aalc_alc_e;
  typedef enum logic [2:0] {
    OUT_NORMAL = 3'b000,
    OUT_COMMON = 3'b001,
    OUT_GROUND = 3'b010,
    OUT_HIZ = 3'b011,
    OUT_HALF = 3'b100
  } aalc_out_e;
  typedef struct packed {
    logic waitreq;
    logic [31:0] rdata;
    logic frame_q;
    logic pd_q;
    logic speaker_power_q;
    logic [6:0] ctrl;
    logic [14:0] cfg;
    logic [6:0] gain;
    logic hp_armed;
    logic init_busy;
    aalc_cnt_t init_cnt;
    logic [7:0] spk_atten;
    aalc_cnt_t spk_lim_cnt;
    aalc_cnt_t spk_rec_cnt;
    logic lim_act;
    aalc_alc_e alc;
    aalc_cnt_t zc_cnt;
    aalc_cnt_t wait_cnt;
    aalc_out_e hp_mode;
    aalc_out_e mono_mode;
    aalc_out_e pos_mode;
    aalc_out_e neg_mode;
  } aalc_state_s;
endpackage

// >>> src/aalc_top.sv
`timescale 1ns/1ps
`include "aalc_consts.svh"
module aalc_top
  import aalc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic power_down_n,
  input wire logic frame_clk,
  input wire logic in_over_l,
  input wire logic in_over_r,
  input wire logic in_band_l,
  input wire logic in_band_r,
  input wire logic in_zero_cross_l,
  input wire logic in_zero_cross_r,
  input wire logic spk_over,
  input wire logic spk_below,
  input wire logic spk_zero_cross,
  output logic [2:0] headphone_left_out,
  output logic [2:0] headphone_right_out,
  output logic [2:0] mono_out,
  output logic [2:0] speaker_out_pos,
  output logic [2:0] speaker_out_neg,
  output logic [6:0] input_gain_code,
  output logic [7:0] speaker_atten,
  output logic speaker_limiter_active
);

  // ---------------------------------------------------------------
  // Reset release
  // ---------------------------------------------------------------
  logic rst_meta_n;
  logic rst_sync_n;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_n <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_sync_n <= rst_meta_n;
    end
  end

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  aalc_state_s s;
  aalc_state_s n;

  logic tick;
  logic pd_rise;
  logic speaker_power_rise;
  logic req;
  logic wr_done;
  logic [31:0] wmask;
  logic [31:0] wv;
  logic [31:0] old_word;
  logic spk_on;
  logic alc_en;
  logic over;
  logic band;
  logic zc;
  logic fire;
  aalc_cnt_t ltm;
  aalc_cnt_t ztm;
  aalc_cnt_t wtm;
  aalc_cnt_t weff;
  aalc_cnt_t lim_tmo;
  logic [6:0] step;
  logic [6:0] target;

  localparam aalc_cnt_t SPK_REC_LAST =
    `AALC_SPK_REC_FS + `AALC_SPK_ZTO_FS - 14'h0001;

  function automatic aalc_cnt_t tmo(input logic [1:0] sel);
    return `AALC_TMO_BASE_FS << sel;
  endfunction

  always_comb begin
    n = s;
    tick = frame_clk & ~s.frame_q;
    pd_rise = power_down_n & ~s.pd_q;
    speaker_power_rise = s.ctrl[`AALC_CTRL_SPEAKER_POWER] & ~s.speaker_power_q;
    n.frame_q = frame_clk;
    n.pd_q = power_down_n;
    n.speaker_power_q = s.ctrl[`AALC_CTRL_SPEAKER_POWER];

    // -------------------------------------------------------------
    // Register bus: one wait cycle, then the transfer completes
    // -------------------------------------------------------------
    req = avs_read | avs_write;
    n.waitreq = ~(req & s.waitreq);
    wr_done = avs_write & ~s.waitreq;
    wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
             {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    unique case (avs_address)
      `AALC_OFS_CTRL: old_word = {25'h0000000, s.ctrl};
      `AALC_OFS_CFG: old_word = {17'h00000, s.cfg};
      `AALC_OFS_GAIN: old_word = {25'h0000000, s.gain};
      `AALC_OFS_STAT: old_word = {20'h00000, s.hp_armed, s.alc,
                                  s.init_busy, s.spk_atten};
      default: old_word = 32'h00000000;
    endcase
    wv = (old_word & ~wmask) | (avs_writedata & wmask);
    if (req & s.waitreq) begin
      n.rdata = avs_read ? old_word : 32'h00000000;
    end
    if (wr_done) begin
      if (avs_address == `AALC_OFS_CTRL) begin
        n.ctrl = wv[6:0];
        if (wv[`AALC_CTRL_HPA] && !s.ctrl[`AALC_CTRL_HPA]) begin
          n.hp_armed = 1'b1;
        end
      end
      if (avs_address == `AALC_OFS_CFG) begin
        n.cfg = wv[14:0];
      end
      if (avs_address == `AALC_OFS_GAIN &&
          !s.ctrl[`AALC_CTRL_ALCEN]) begin
        n.gain = wv[6:0];
      end
    end
    if (pd_rise || !power_down_n) begin
      n.hp_armed = 1'b0;
    end

    // -------------------------------------------------------------
    // Speaker limiter
    // -------------------------------------------------------------
    spk_on = s.ctrl[`AALC_CTRL_SPEAKER_POWER] & power_down_n;
    if (pd_rise || speaker_power_rise) begin
      n.init_busy = 1'b1;
      n.init_cnt = '0;
      n.spk_atten = 8'h00;
      n.spk_lim_cnt = '0;
      n.spk_rec_cnt = '0;
    end else if (!spk_on) begin
      n.init_busy = 1'b0;
      n.spk_atten = 8'h00;
      n.spk_lim_cnt = '0;
      n.spk_rec_cnt = '0;
    end else if (s.init_busy) begin
      if (tick) begin
        if (s.init_cnt == `AALC_SPK_INIT_FS - 14'h0001) begin
          n.init_busy = 1'b0;
        end else begin
          n.init_cnt = s.init_cnt + 14'h0001;
        end
      end
    end else if (tick) begin
      if (spk_over) begin
        n.spk_rec_cnt = '0;
        if (s.spk_lim_cnt >= `AALC_SPK_LIM_FS - 14'h0001) begin
          n.spk_lim_cnt = '0;
          if (s.spk_atten != 8'hFF) begin
            n.spk_atten = s.spk_atten + 8'h01;
          end
        end else begin
          n.spk_lim_cnt = s.spk_lim_cnt + 14'h0001;
        end
      end else if (spk_below && s.spk_atten != 8'h00) begin
        n.spk_lim_cnt = '0;
        if ((s.spk_rec_cnt >= `AALC_SPK_REC_FS - 14'h0001 &&
             spk_zero_cross) || s.spk_rec_cnt == SPK_REC_LAST) begin
          n.spk_rec_cnt = '0;
          n.spk_atten = (s.spk_atten > 8'h02) ?
                        s.spk_atten - 8'h02 : 8'h00;
        end else begin
          n.spk_rec_cnt = s.spk_rec_cnt + 14'h0001;
        end
      end else begin
        n.spk_lim_cnt = '0;
        n.spk_rec_cnt = '0;
      end
    end
    n.lim_act = spk_on & ~s.init_busy;

    // -------------------------------------------------------------
    // Input level controller
    // -------------------------------------------------------------
    alc_en = s.ctrl[`AALC_CTRL_ALCEN] & power_down_n;
    over = in_over_l | in_over_r;
    band = in_band_l | in_band_r;
    zc = in_zero_cross_l | in_zero_cross_r;
    ltm = tmo(s.cfg[`AALC_CFG_LTM +: 2]);
    ztm = tmo(s.cfg[`AALC_CFG_ZTM +: 2]);
    wtm = tmo(s.cfg[`AALC_CFG_WTM +: 2]);
    weff = (wtm < ztm) ? ztm : wtm;
    lim_tmo = s.ctrl[`AALC_CTRL_ZCD] ? ltm : ztm;
    step = {5'h00, s.cfg[`AALC_CFG_LMAT +: 2]} + 7'h01;
    target = s.cfg[`AALC_CFG_REF +: 7];
    fire = 1'b0;
    if (!alc_en) begin
      n.alc = ALC_IDLE;
      n.zc_cnt = '0;
      n.wait_cnt = '0;
    end else if (tick) begin
      if (s.zc_cnt != '0) begin
        n.zc_cnt = (s.zc_cnt >= ztm) ? '0 : s.zc_cnt + 14'h0001;
      end
      unique case (s.alc)
        ALC_IDLE: begin
          if (over) begin
            n.alc = ALC_LIMIT;
            n.zc_cnt = (s.zc_cnt == '0) ? 14'h0001 :
                       s.zc_cnt + 14'h0001;
          end
        end
        ALC_LIMIT: begin
          if (s.ctrl[`AALC_CTRL_ZCD]) begin
            fire = s.zc_cnt >= lim_tmo;
          end else begin
            fire = zc || s.zc_cnt >= lim_tmo;
          end
          if (fire) begin
            n.gain = (s.gain > step) ? s.gain - step : 7'h00;
            if (over) begin
              n.zc_cnt = 14'h0001;
            end else begin
              n.zc_cnt = '0;
              n.alc = ALC_WAIT;
              n.wait_cnt = '0;
            end
          end else begin
            n.zc_cnt = s.zc_cnt + 14'h0001;
          end
        end
        ALC_WAIT: begin
          if (over) begin
            n.alc = ALC_LIMIT;
            n.zc_cnt = (s.zc_cnt == '0) ? 14'h0001 :
                       s.zc_cnt + 14'h0001;
          end else if (band) begin
            n.wait_cnt = '0;
          end else if (s.wait_cnt >= wtm && (zc || s.wait_cnt >= weff) &&
                       s.gain < target) begin
            n.gain = s.gain + 7'h01;
            n.wait_cnt = '0;
            n.zc_cnt = 14'h0001;
          end else if (s.wait_cnt != 14'h3FFF) begin
            n.wait_cnt = s.wait_cnt + 14'h0001;
          end
        end
        default: n.alc = ALC_IDLE;
      endcase
    end

    // -------------------------------------------------------------
    // Output stage modes
    // -------------------------------------------------------------
    if (!power_down_n || !s.ctrl[`AALC_CTRL_HPP]) begin
      n.hp_mode = OUT_GROUND;
    end else if (!s.ctrl[`AALC_CTRL_HPA] || !s.hp_armed) begin
      n.hp_mode = OUT_COMMON;
    end else begin
      n.hp_mode = OUT_NORMAL;
    end
    if (!spk_on) begin
      n.mono_mode = OUT_HIZ;
      n.pos_mode = OUT_HIZ;
      n.neg_mode = OUT_HIZ;
    end else begin
      n.mono_mode = s.ctrl[`AALC_CTRL_MONO] ? OUT_NORMAL : OUT_COMMON;
      if (!s.ctrl[`AALC_CTRL_SPSN]) begin
        n.pos_mode = OUT_HIZ;
        n.neg_mode = OUT_HALF;
      end else begin
        n.pos_mode = OUT_NORMAL;
        n.neg_mode = OUT_NORMAL;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      s.waitreq <= 1'b1;
      s.rdata <= 32'h00000000;
      s.frame_q <= 1'b0;
      s.pd_q <= 1'b0;
      s.speaker_power_q <= 1'b0;
      s.ctrl <= `AALC_CTRL_RST;
      s.cfg <= `AALC_CFG_RST;
      s.gain <= `AALC_GAIN_RST;
      s.hp_armed <= 1'b0;
      s.init_busy <= 1'b0;
      s.init_cnt <= '0;
      s.spk_atten <= 8'h00;
      s.spk_lim_cnt <= '0;
      s.spk_rec_cnt <= '0;
      s.lim_act <= 1'b0;
      s.alc <= ALC_IDLE;
      s.zc_cnt <= '0;
      s.wait_cnt <= '0;
      s.hp_mode <= OUT_GROUND;
      s.mono_mode <= OUT_HIZ;
      s.pos_mode <= OUT_HIZ;
      s.neg_mode <= OUT_HIZ;
    end else begin
      s <= n;
    end
  end

  assign avs_readdata = s.rdata;
  assign avs_waitrequest = s.waitreq;
  assign headphone_left_out = s.hp_mode;
  assign headphone_right_out = s.hp_mode;
  assign mono_out = s.mono_mode;
  assign speaker_out_pos = s.pos_mode;
  assign speaker_out_neg = s.neg_mode;
  assign input_gain_code = s.gain;
  assign speaker_atten = s.spk_atten;
  assign speaker_limiter_active = s.lim_act;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_sync_n);

  a_hp_save_level: assert property (
    power_down_n && s.ctrl[`AALC_CTRL_HPP] && !s.ctrl[`AALC_CTRL_HPA]
    |=> s.hp_mode == OUT_COMMON)
    else $error("headphone not in power-save");
  a_hp_power_off: assert property (
    !s.ctrl[`AALC_CTRL_HPP] |=> s.hp_mode == OUT_GROUND)
    else $error("headphone not grounded");
  a_pd_rise_save: assert property (
    power_down_n && !s.pd_q |=> s.hp_mode != OUT_NORMAL [*2])
    else $error("headphone normal after pin rise");
  a_spk_off_hiz: assert property (
    !s.ctrl[`AALC_CTRL_SPEAKER_POWER] |=> s.mono_mode == OUT_HIZ &&
    s.pos_mode == OUT_HIZ && s.neg_mode == OUT_HIZ)
    else $error("speaker outputs not high impedance");
  a_spk_save_pins: assert property (
    power_down_n && s.ctrl[`AALC_CTRL_SPEAKER_POWER] && !s.ctrl[`AALC_CTRL_SPSN]
    |=> s.pos_mode == OUT_HIZ && s.neg_mode == OUT_HALF)
    else $error("speaker save pins wrong");
  a_mono_off_com: assert property (
    power_down_n && s.ctrl[`AALC_CTRL_SPEAKER_POWER] && !s.ctrl[`AALC_CTRL_MONO]
    |=> s.mono_mode == OUT_COMMON)
    else $error("mono not at common level");
  a_spk_att_cause: assert property (
    s.spk_atten > $past(s.spk_atten) |->
    $past(spk_over) && $past(tick) && !$past(s.init_busy))
    else $error("speaker attenuation without cause");
  a_spk_init_hold: assert property (
    s.init_busy |=> s.spk_atten == 8'h00 && !s.lim_act)
    else $error("speaker limiter active during init");
  a_gain_wr_ignore: assert property (
    wr_done && avs_address == `AALC_OFS_GAIN &&
    s.ctrl[`AALC_CTRL_ALCEN] && !tick |=> $stable(s.gain))
    else $error("gain write taken while enabled");
  a_limit_dec_src: assert property (
    s.gain < $past(s.gain) && !$past(wr_done) |->
    $past(s.alc) == ALC_LIMIT)
    else $error("gain lowered outside limiting");
  a_over_to_limit: assert property (
    alc_en && tick && over && s.alc == ALC_WAIT |=> s.alc == ALC_LIMIT)
    else $error("recovery did not switch to limiting");
  a_band_wait_rst: assert property (
    alc_en && tick && !over && band && s.alc == ALC_WAIT
    |=> s.wait_cnt == '0 && $stable(s.gain))
    else $error("band did not reset wait timer");
endmodule

// >>> tb/aalc_src.sv
`timescale 1ns/1ps
module aalc_src (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [1:0] level,
  input wire logic zc_on,
  output logic frame_clk,
  output logic over_l,
  output logic over_r,
  output logic band,
  output logic zc,
  output logic spk_over,
  output logic spk_below
);
  logic [2:0] div_r;
  logic [1:0] zc_cnt_r;

  // One sample strobe every eight clocks
  assign frame_clk = div_r[2];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_r <= 3'h0;
      zc_cnt_r <= 2'h0;
      over_l <= 1'b0;
      over_r <= 1'b0;
      band <= 1'b0;
      zc <= 1'b0;
      spk_over <= 1'b0;
      spk_below <= 1'b0;
    end else begin
      div_r <= div_r + 3'h1;
      // Comparators settle two clocks ahead of the strobe edge
      if (div_r == 3'h1) begin
        zc_cnt_r <= zc_cnt_r + 2'h1;
        over_l <= (level == 2'h2);
        over_r <= (level == 2'h3);
        band <= (level == 2'h1);
        spk_over <= level[1];
        spk_below <= (level == 2'h0);
        zc <= zc_on && (zc_cnt_r == 2'h3);
      end
    end
  end
endmodule

// >>> tb/aalc_top_tb.sv
`timescale 1ns/1ps
`include "aalc_consts.svh"
module aalc_top_tb;
  import aalc_pkg::*;
  logic clk, rst_n, avs_read, avs_write, power_down_n, frame_clk;
  logic [3:0] avs_address, avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic avs_waitrequest, over_l, over_r, band, zc, spk_over, spk_below;
  logic [2:0] hp_l, hp_r, mono, pos, neg;
  logic [6:0] gain, g;
  logic [7:0] atten, a;
  logic lim_act, zc_on;
  logic [1:0] level;
  int fails, compares;

  aalc_top dut (.clk(clk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .power_down_n(power_down_n), .frame_clk(frame_clk),
    .in_over_l(over_l), .in_over_r(over_r), .in_band_l(band),
    .in_band_r(band), .in_zero_cross_l(zc), .in_zero_cross_r(zc),
    .spk_over(spk_over), .spk_below(spk_below), .spk_zero_cross(zc),
    .headphone_left_out(hp_l), .headphone_right_out(hp_r),
    .mono_out(mono), .speaker_out_pos(pos), .speaker_out_neg(neg),
    .input_gain_code(gain), .speaker_atten(atten),
    .speaker_limiter_active(lim_act));

  aalc_src src (.clk(clk), .rst_n(rst_n), .level(level), .zc_on(zc_on),
    .frame_clk(frame_clk), .over_l(over_l), .over_r(over_r), .band(band),
    .zc(zc), .spk_over(spk_over), .spk_below(spk_below));

  always #5 clk = ~clk;

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic final_report;
    $display("Checks %0d, mismatches %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Holds the request until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [3:0] ad,
                     input logic [31:0] d);
    int n;
    @(posedge clk);
    avs_address <= ad;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (avs_waitrequest !== 1'b0) begin
      fails++;
      final_report();
    end
  endtask

  task automatic strobes(input int n);
    repeat (n) @(posedge frame_clk);
    repeat (3) @(posedge clk);
  endtask

  task automatic wait_gain(input int n);
    int i;
    g = gain;
    i = 0;
    while (gain === g && i < n) begin
      @(posedge frame_clk);
      i++;
    end
    @(posedge clk);
    if (gain === g) begin
      fails++;
      final_report();
    end
  endtask

  initial begin
    repeat (100000) @(posedge clk);
    fails++;
    final_report();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    avs_address = 4'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hF;
    power_down_n = 1'b0;
    level = 2'h0;
    zc_on = 1'b0;
    fails = 0;
    compares = 0;
    repeat (4) @(posedge clk);
    check(32'(hp_l), 32'(OUT_GROUND));
    check(32'(mono), 32'(OUT_HIZ));
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    bus(1'b0, `AALC_OFS_CFG, 32'h0);
    check(rd, 32'h3000);
    bus(1'b0, `AALC_OFS_GAIN, 32'h0);
    check(rd, 32'h10);
    bus(1'b1, 4'h2, 32'hFFFFFFFF);
    bus(1'b0, 4'h2, 32'h0);
    check(rd, 32'h0);
    // Headphone path
    power_down_n <= 1'b1;
    bus(1'b1, `AALC_OFS_CTRL, 32'h02);
    repeat (4) @(posedge clk);
    check(32'(hp_l), 32'(OUT_COMMON));
    bus(1'b1, `AALC_OFS_CTRL, 32'h03);
    bus(1'b0, `AALC_OFS_CTRL, 32'h0);
    check(rd, 32'h03);
    check(32'(hp_r), 32'(OUT_NORMAL));
    power_down_n <= 1'b0;
    repeat (4) @(posedge clk);
    check(32'(hp_l), 32'(OUT_GROUND));
    power_down_n <= 1'b1;
    repeat (4) @(posedge clk);
    check(32'(hp_l), 32'(OUT_COMMON));
    bus(1'b1, `AALC_OFS_CTRL, 32'h01);
    repeat (4) @(posedge clk);
    check(32'(hp_r), 32'(OUT_GROUND));
    // ----------------------------------------
    // Speaker path and its limiter
    // ----------------------------------------
    bus(1'b1, `AALC_OFS_CTRL, 32'h06);
    repeat (4) @(posedge clk);
    check(32'(pos), 32'(OUT_HIZ));
    check(32'(neg), 32'(OUT_HALF));
    check(32'(mono), 32'(OUT_COMMON));
    bus(1'b1, `AALC_OFS_CTRL, 32'h1E);
    repeat (4) @(posedge clk);
    check(32'(pos), 32'(OUT_NORMAL));
    check(32'(mono), 32'(OUT_NORMAL));
    level <= 2'h2;
    strobes(1000);
    check(32'(atten), 32'h0);
    check(32'(lim_act), 32'h0);
    level <= 2'h1;
    strobes(1060);
    check(32'(lim_act), 32'h1);
    level <= 2'h2;
    strobes(20);
    level <= 2'h1;
    strobes(3);
    a = atten;
    check(32'(a >= 8'h09 && a <= 8'h0C), 32'h1);
    strobes(100);
    check(32'(atten), 32'(a));
    level <= 2'h0;
    zc_on <= 1'b1;
    strobes(1900);
    check(32'(atten), 32'(a));
    strobes(250);
    check(32'(atten), 32'(a - 8'h02));
    bus(1'b1, `AALC_OFS_CTRL, 32'h03);
    repeat (4) @(posedge clk);
    check(32'(mono), 32'(OUT_HIZ));
    check(32'(pos), 32'(OUT_HIZ));
    check(32'(neg), 32'(OUT_HIZ));
    check(32'(lim_act), 32'h0);
    // ----------------------------------------
    // Input level controller
    // ----------------------------------------
    bus(1'b1, `AALC_OFS_CFG, 32'h1005);
    bus(1'b1, `AALC_OFS_CTRL, 32'h23);
    bus(1'b1, `AALC_OFS_GAIN, 32'h05);
    repeat (4) @(posedge clk);
    check(32'(gain), 32'h10);
    level <= 2'h2;
    wait_gain(20);
    level <= 2'h1;
    check(32'(gain), 32'h0E);
    // Over was still seen at the first step, so one more step is pending
    strobes(4);
    check(32'(gain), 32'h0C);
    bus(1'b0, `AALC_OFS_STAT, 32'h0);
    check(32'(rd[10:9]), 32'h2);
    strobes(300);
    check(32'(gain), 32'h0C);
    level <= 2'h0;
    strobes(100);
    check(32'(gain), 32'h0C);
    strobes(60);
    check(32'(gain), 32'h0D);
    strobes(200);
    check(32'(gain), 32'h0E);
    strobes(300);
    check(32'(gain), 32'h10);
    level <= 2'h3;
    wait_gain(20);
    level <= 2'h1;
    check(32'(gain), 32'h0E);
    bus(1'b1, `AALC_OFS_CTRL, 32'h63);
    zc_on <= 1'b0;
    level <= 2'h2;
    // The shorter zero-cross timeout would have stepped by now
    strobes(150);
    check(32'(gain), 32'h0E);
    wait_gain(150);
    level <= 2'h1;
    check(32'(gain), 32'h0C);
    final_report();
  end
endmodule
